// ### hw/scl_pkg.sv
// Shared constants and types for the serial configuration ROM loader
package scl_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PORTS           = 6;
  localparam int unsigned MCLK_MHZ            = 125;
  localparam int unsigned ROM_ACK_TIMEOUT_US  = 1000;
  localparam int unsigned ROM_ACK_TIMEOUT_CYC = ROM_ACK_TIMEOUT_US * MCLK_MHZ;
  localparam int unsigned TIMER_W             = 18;

  // ----------------------------------------------------------------
  // ROM word byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  ROM_SIG_ADDR   = 8'h00;
  localparam logic [7:0]  ROM_VID_ADDR   = 8'h02;
  localparam logic [7:0]  ROM_DID_ADDR   = 8'h04;
  localparam logic [7:0]  ROM_W06_ADDR   = 8'h06;
  localparam logic [7:0]  ROM_SVID_ADDR  = 8'h08;
  localparam logic [7:0]  ROM_SID_ADDR   = 8'h0a;
  localparam logic [7:0]  ROM_W0C_ADDR   = 8'h0c;
  localparam logic [7:0]  ROM_W0E_ADDR   = 8'h0e;
  localparam logic [7:0]  ROM_W10_ADDR   = 8'h10;
  localparam logic [7:0]  ROM_W12_ADDR   = 8'h12;
  localparam logic [7:0]  ROM_W14_ADDR   = 8'h14;
  localparam logic [7:0]  ROM_W16_ADDR   = 8'h16;
  localparam logic [7:0]  ROM_W18_ADDR   = 8'h18;
  localparam logic [7:0]  ROM_W1A_ADDR   = 8'h1a;
  localparam logic [7:0]  ROM_W1C_ADDR   = 8'h1c;
  localparam logic [7:0]  ROM_W1E_ADDR   = 8'h1e;
  localparam logic [3:0]  ROM_FIRST_IDX  = 4'h0;
  localparam logic [3:0]  ROM_LAST_IDX   = 4'hf;
  localparam logic [15:0] ROM_SIG_VALUE  = 16'h1516;

  // Identification defaults; values are arbitrary
  localparam logic [15:0] ID_VENDOR_DEF  = 16'h0001;
  localparam logic [15:0] ID_DEVICE_DEF  = 16'h0002;
  localparam logic [15:0] ID_SVENDOR_DEF = 16'h0003;
  localparam logic [15:0] ID_SUBSYS_DEF  = 16'h0004;

  // ----------------------------------------------------------------
  // ROM word layouts, most significant bit first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       np_sf_only;
    logic       credit_mode;
    logic       arb_mode;
    logic [1:0] ct_thresh;
    logic       store_fwd;
    logic       no_tag_order;
    logic       no_egress_order;
    logic       clk_pm;
    logic [2:0] l1_exit;
    logic [2:0] l0s_exit;
    logic       vc_count;
  } scl_w06_type;

  typedef struct packed {
    logic       bound4k;
    logic       ltr_en;
    logic       pmdata_wr;
    logic       surprise_down;
    logic       sof_mode;
    logic       order_frozen;
    logic       bw_notify;
    logic       post_pass;
    logic       pm_dis;
    logic       cpar_dis;
    logic       msi_dis;
    logic       role_err;
    logic [1:0] aspm;
    logic [1:0] max_payload;
  } scl_w0c_type;

  typedef struct packed {
    logic       flag;
    logic [4:0] half;
    logic [4:0] b;
    logic [4:0] a;
  } scl_tri5_type;

  typedef struct packed {
    logic       spare;
    logic       chflag_sel;
    logic       grant_idle;
    logic       req_abort;
    logic [4:0] half_delta;
    logic [2:0] rx_detect;
    logic [3:0] tx_latency;
  } scl_w14_type;

  typedef struct packed {
    logic [7:0] refclk_buf;
    logic [7:0] phy_b_hi;
  } scl_w1c_type;

  typedef struct packed {
    logic [9:0] spare;
    logic [1:0] half;
    logic [1:0] b;
    logic [1:0] a;
  } scl_w1e_type;

  // ----------------------------------------------------------------
  // Per-port destination fields
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       np_sf_only;
    logic       no_tag_order;
    logic       no_egress_order;
    logic       credit_mode;
    logic       arb_mode;
    logic [1:0] ct_thresh;
    logic       store_fwd;
  } scl_sw_mode_type;

  typedef struct packed {
    logic            ext_vc_count;
    logic [2:0]      l0s_exit_latency;
    logic [2:0]      l1_exit_latency;
    logic            clock_pm_cap;
    logic [1:0]      aspm_support;
    logic            bw_notify_cap;
    logic            surprise_down_cap;
    logic [1:0]      max_payload_support;
    logic            role_based_err;
    logic            msi_cap_disable;
    logic            pm_cap_disable;
    scl_sw_mode_type switch_mode;
    logic            compliance_parity_disable;
    logic [4:0]      nominal_drive_level_a;
    logic [4:0]      nominal_drive_level_b;
    logic [4:0]      nominal_drive_level_half;
    logic [4:0]      gen1_post_emphasis_nominal;
    logic [4:0]      gen2_post_emphasis_nominal_a;
    logic [4:0]      gen2_post_emphasis_nominal_b;
    logic            int_pin_a_req;
    logic [3:0]      transmit_phy_latency;
    logic [2:0]      receiver_detect_microseconds;
    logic [31:0]     vendor_phy_control_a;
    logic [23:0]     vendor_phy_control_b;
    logic            post_pass_np;
    logic            ordering_frozen;
    logic            pm_data_sel_writable;
    logic            boundary_4k_check;
    logic            tx_sof_latency_mode;
    logic            gen2_mode_control;
    logic            request_abort_select;
    logic            grant_fail_to_idle;
    logic            arbiter_channel_flag_select;
    logic [4:0]      half_swing_emphasis_delta;
    logic [1:0]      drive_level_delta_a;
    logic [1:0]      drive_level_delta_b;
    logic [1:0]      drive_level_delta_half;
    logic [4:0]      margin_drive_level_a;
    logic [4:0]      margin_drive_level_b;
    logic [4:0]      margin_drive_level_half;
    logic [7:0]      refclk_buffer_control;
    logic            ltr_enable;
    logic            obff_enable;
  } scl_port_cfg_type;

  localparam scl_port_cfg_type PORT_CFG_RESET = '0;

  // Loaded word as broadcast to the port banks
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [15:0] data;
  } scl_word_type;

  typedef enum logic [2:0] {
    ST_CLEAR = 3'b000,
    ST_READ  = 3'b001,
    ST_GAP   = 3'b010,
    ST_FLUSH = 3'b011,
    ST_DONE  = 3'b100,
    ST_FAIL  = 3'b101
  } scl_state_type;

endpackage

// ### hw/scl_port_bank.sv
// Configuration fields of one switch port, loaded from ROM words
`timescale 1ns/10ps
module scl_port_bank
  import scl_pkg::*;
#(
  parameter int unsigned PORT_IDX = 0
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Load stream
  input  wire logic              clear,
  input  wire scl_word_type      word,
  // Loaded fields
  output      scl_port_cfg_type  cfg
);

  localparam logic IS_PORT0 = (PORT_IDX == 0);

  scl_port_cfg_type cfg_q;
  scl_port_cfg_type cfg_d;

  // ----------------------------------------------------------------
  // Word decode
  // ----------------------------------------------------------------
  wire logic        hit_06 = word.valid && (word.addr == ROM_W06_ADDR);
  wire logic        hit_0c = word.valid && (word.addr == ROM_W0C_ADDR);
  wire logic        hit_0e = word.valid && (word.addr == ROM_W0E_ADDR);
  wire logic        hit_10 = word.valid && (word.addr == ROM_W10_ADDR);
  wire logic        hit_12 = word.valid && (word.addr == ROM_W12_ADDR);
  wire logic        hit_14 = word.valid && (word.addr == ROM_W14_ADDR);
  wire logic        hit_16 = word.valid && (word.addr == ROM_W16_ADDR);
  wire logic        hit_18 = word.valid && (word.addr == ROM_W18_ADDR);
  wire logic        hit_1a = word.valid && (word.addr == ROM_W1A_ADDR);
  wire logic        hit_1c = word.valid && (word.addr == ROM_W1C_ADDR);
  wire logic        hit_1e = word.valid && (word.addr == ROM_W1E_ADDR);
  wire scl_w06_type w06    = scl_w06_type'(word.data);
  wire scl_w0c_type w0c    = scl_w0c_type'(word.data);
  wire scl_tri5_type w3    = scl_tri5_type'(word.data);
  wire scl_w14_type w14    = scl_w14_type'(word.data);
  wire scl_w1c_type w1c    = scl_w1c_type'(word.data);
  wire scl_w1e_type w1e    = scl_w1e_type'(word.data);

  // ----------------------------------------------------------------
  // Field update
  // ----------------------------------------------------------------
  always_comb begin
    cfg_d = cfg_q;
    if (clear) begin
      cfg_d = PORT_CFG_RESET;
    end else begin
      if (hit_06) begin
        cfg_d.ext_vc_count     = w06.vc_count;
        cfg_d.l0s_exit_latency = w06.l0s_exit;
        cfg_d.l1_exit_latency  = w06.l1_exit;
        cfg_d.clock_pm_cap     = w06.clk_pm;
        if (IS_PORT0) begin
          cfg_d.switch_mode.no_egress_order = w06.no_egress_order;
          cfg_d.switch_mode.no_tag_order    = w06.no_tag_order;
          cfg_d.switch_mode.store_fwd       = w06.store_fwd;
          cfg_d.switch_mode.ct_thresh       = w06.ct_thresh;
          cfg_d.switch_mode.arb_mode        = w06.arb_mode;
          cfg_d.switch_mode.credit_mode     = w06.credit_mode;
          cfg_d.switch_mode.np_sf_only      = w06.np_sf_only;
        end
      end
      if (hit_0c) begin
        cfg_d.max_payload_support       = w0c.max_payload;
        cfg_d.aspm_support              = w0c.aspm;
        cfg_d.role_based_err            = w0c.role_err;
        cfg_d.msi_cap_disable           = w0c.msi_dis;
        cfg_d.compliance_parity_disable = w0c.cpar_dis;
        cfg_d.pm_cap_disable            = w0c.pm_dis;
        cfg_d.post_pass_np              = w0c.post_pass;
        cfg_d.ordering_frozen           = w0c.order_frozen;
        cfg_d.pm_data_sel_writable      = w0c.pmdata_wr;
        cfg_d.boundary_4k_check         = w0c.bound4k;
        // Zero here selects the shorter start-of-frame latency
        cfg_d.tx_sof_latency_mode       = w0c.sof_mode;
        if (!IS_PORT0) begin
          cfg_d.bw_notify_cap = w0c.bw_notify;
        end
        cfg_d.surprise_down_cap         = w0c.surprise_down;
        cfg_d.ltr_enable                = w0c.ltr_en;
      end
      if (hit_0e) begin
        cfg_d.margin_drive_level_a    = w3.a;
        cfg_d.margin_drive_level_b    = w3.b;
        cfg_d.margin_drive_level_half = w3.half;
        cfg_d.obff_enable             = w3.flag;
      end
      if (hit_10) begin
        cfg_d.nominal_drive_level_a    = w3.a;
        cfg_d.nominal_drive_level_b    = w3.b;
        cfg_d.nominal_drive_level_half = w3.half;
        cfg_d.gen2_mode_control        = w3.flag;
      end
      if (hit_12) begin
        cfg_d.gen1_post_emphasis_nominal   = w3.a;
        cfg_d.gen2_post_emphasis_nominal_a = w3.b;
        cfg_d.gen2_post_emphasis_nominal_b = w3.half;
        if (!IS_PORT0) begin
          cfg_d.int_pin_a_req = w3.flag;
        end
      end
      if (hit_14) begin
        cfg_d.transmit_phy_latency         = w14.tx_latency;
        cfg_d.receiver_detect_microseconds = w14.rx_detect;
        cfg_d.half_swing_emphasis_delta    = w14.half_delta;
        cfg_d.request_abort_select         = w14.req_abort;
        cfg_d.grant_fail_to_idle           = w14.grant_idle;
        cfg_d.arbiter_channel_flag_select  = w14.chflag_sel;
      end
      if (hit_16) begin
        cfg_d.vendor_phy_control_a[15:0] = word.data;
      end
      if (hit_18) begin
        cfg_d.vendor_phy_control_a[31:16] = word.data;
      end
      if (hit_1a) begin
        cfg_d.vendor_phy_control_b[15:0] = word.data;
      end
      if (hit_1c) begin
        cfg_d.vendor_phy_control_b[23:16] = w1c.phy_b_hi;
        cfg_d.refclk_buffer_control       = w1c.refclk_buf;
      end
      if (hit_1e) begin
        cfg_d.drive_level_delta_a    = w1e.a;
        cfg_d.drive_level_delta_b    = w1e.b;
        cfg_d.drive_level_delta_half = w1e.half;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg_q <= PORT_CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg = cfg_q;

endmodule

// ### hw/scl_loader.sv
// Serial configuration ROM loader: sequences ROM reads and fills port fields
`timescale 1ns/10ps
module scl_loader
  import scl_pkg::*;
#(
  parameter int unsigned ACK_TIMEOUT_CYC = ROM_ACK_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                               mclk,
  input  wire logic                               rst,
  // Load control
  input  wire logic                               load_req,
  // ROM word read port
  output      logic                               rom_req,
  output      logic [7:0]                         rom_addr,
  input  wire logic                               rom_ack,
  input  wire logic [15:0]                        rom_data,
  // Identification words
  output      logic [15:0]                        cfg_vendor_id,
  output      logic [15:0]                        cfg_device_id,
  output      logic [15:0]                        cfg_subsys_vendor_id,
  output      logic [15:0]                        cfg_subsys_id,
  // Per-port loaded fields
  output      scl_port_cfg_type [NUM_PORTS-1:0]   port_cfg,
  // Load status
  output      logic                               load_busy,
  output      logic                               load_done,
  output      logic                               load_sig_bad,
  output      logic                               load_timeout
);

  localparam logic [TIMER_W-1:0] ACK_LIMIT = TIMER_W'(ACK_TIMEOUT_CYC - 1);

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  scl_state_type      state_q;
  scl_state_type      state_d;
  logic [3:0]         idx_q;
  logic [3:0]         idx_d;
  logic               req_q;
  logic               req_d;
  logic [7:0]         addr_q;
  logic [7:0]         addr_d;
  logic [TIMER_W-1:0] timer_q;
  logic [TIMER_W-1:0] timer_d;
  scl_word_type       word_q;
  scl_word_type       word_d;
  logic               clear_q;
  logic               clear_d;
  logic               busy_q;
  logic               done_q;
  logic               done_d;
  logic               sig_bad_q;
  logic               sig_bad_d;
  logic               timeout_q;
  logic               timeout_d;
  logic [15:0]        vid_q;
  logic [15:0]        did_q;
  logic [15:0]        svid_q;
  logic [15:0]        sid_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic       taken     = req_q && rom_ack;
  wire logic       at_sig    = (idx_q == ROM_FIRST_IDX);
  wire logic       at_last   = (idx_q == ROM_LAST_IDX);
  wire logic       sig_ok    = (rom_data == ROM_SIG_VALUE);
  wire logic       timer_end = (timer_q == ACK_LIMIT);
  wire logic [7:0] next_addr = {3'h0, idx_q + 4'h1, 1'b0};
  wire logic       restart   = load_req && (state_q == ST_DONE || state_q == ST_FAIL);
  wire logic       wr_vid    = word_q.valid && (word_q.addr == ROM_VID_ADDR);
  wire logic       wr_did    = word_q.valid && (word_q.addr == ROM_DID_ADDR);
  wire logic       wr_svid   = word_q.valid && (word_q.addr == ROM_SVID_ADDR);
  wire logic       wr_sid    = word_q.valid && (word_q.addr == ROM_SID_ADDR);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    idx_d     = idx_q;
    req_d     = req_q;
    addr_d    = addr_q;
    timer_d   = timer_q;
    word_d    = '0;
    clear_d   = 1'b0;
    done_d    = done_q;
    sig_bad_d = sig_bad_q;
    timeout_d = timeout_q;
    case (state_q)
      ST_CLEAR: begin
        // Every pass starts from defaults so a rejected image leaves them
        clear_d   = 1'b1;
        idx_d     = ROM_FIRST_IDX;
        addr_d    = ROM_SIG_ADDR;
        req_d     = 1'b1;
        timer_d   = '0;
        done_d    = 1'b0;
        sig_bad_d = 1'b0;
        timeout_d = 1'b0;
        state_d   = ST_READ;
      end
      ST_READ: begin
        if (taken) begin
          req_d   = 1'b0;
          timer_d = '0;
          if (at_sig && !sig_ok) begin
            sig_bad_d = 1'b1;
            state_d   = ST_FAIL;
          end else begin
            word_d.valid = 1'b1;
            word_d.addr  = addr_q;
            word_d.data  = rom_data;
            state_d      = at_last ? ST_FLUSH : ST_GAP;
          end
        end else if (timer_end) begin
          req_d     = 1'b0;
          timeout_d = 1'b1;
          state_d   = ST_FAIL;
        end else begin
          timer_d = timer_q + TIMER_W'(1);
        end
      end
      ST_GAP: begin
        idx_d   = idx_q + 4'h1;
        addr_d  = next_addr;
        req_d   = 1'b1;
        state_d = ST_READ;
      end
      ST_FLUSH: begin
        done_d  = 1'b1;
        state_d = ST_DONE;
      end
      ST_DONE: begin
        if (restart) begin
          state_d = ST_CLEAR;
        end
      end
      ST_FAIL: begin
        if (restart) begin
          state_d = ST_CLEAR;
        end
      end
      default: begin
        req_d   = 1'b0;
        state_d = ST_CLEAR;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_CLEAR;
      idx_q     <= ROM_FIRST_IDX;
      req_q     <= 1'b0;
      addr_q    <= ROM_SIG_ADDR;
      timer_q   <= '0;
      word_q    <= '0;
      clear_q   <= 1'b0;
      busy_q    <= 1'b1;
      done_q    <= 1'b0;
      sig_bad_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      idx_q     <= idx_d;
      req_q     <= req_d;
      addr_q    <= addr_d;
      timer_q   <= timer_d;
      word_q    <= word_d;
      clear_q   <= clear_d;
      busy_q    <= (state_d != ST_DONE) && (state_d != ST_FAIL);
      done_q    <= done_d;
      sig_bad_q <= sig_bad_d;
      timeout_q <= timeout_d;
    end
  end

  // ----------------------------------------------------------------
  // Identification words
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vid_q  <= ID_VENDOR_DEF;
      did_q  <= ID_DEVICE_DEF;
      svid_q <= ID_SVENDOR_DEF;
      sid_q  <= ID_SUBSYS_DEF;
    end else if (clear_q) begin
      vid_q  <= ID_VENDOR_DEF;
      did_q  <= ID_DEVICE_DEF;
      svid_q <= ID_SVENDOR_DEF;
      sid_q  <= ID_SUBSYS_DEF;
    end else begin
      vid_q  <= wr_vid  ? word_q.data : vid_q;
      did_q  <= wr_did  ? word_q.data : did_q;
      svid_q <= wr_svid ? word_q.data : svid_q;
      sid_q  <= wr_sid  ? word_q.data : sid_q;
    end
  end

  // ----------------------------------------------------------------
  // Port banks, one loaded word fanned out to all ports
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    scl_port_bank #(
      .PORT_IDX (p)
    ) u_bank (
      .mclk  (mclk),
      .rst   (rst),
      .clear (clear_q),
      .word  (word_q),
      .cfg   (port_cfg[p])
    );
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rom_req              = req_q;
  assign rom_addr             = addr_q;
  assign cfg_vendor_id        = vid_q;
  assign cfg_device_id        = did_q;
  assign cfg_subsys_vendor_id = svid_q;
  assign cfg_subsys_id        = sid_q;
  assign load_busy            = busy_q;
  assign load_done            = done_q;
  assign load_sig_bad         = sig_bad_q;
  assign load_timeout         = timeout_q;

endmodule

// ### sim/scl_rom_model.sv
// Behavioural configuration ROM answering word reads dly+1 clocks after the request, unless muted
`timescale 1ns/10ps
module scl_rom_model (
  // Clock, reset and behaviour select
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [3:0]  dly,
  input  wire logic        mute,
  // Word read port
  input  wire logic        rom_req,
  input  wire logic [7:0]  rom_addr,
  output      logic        rom_ack,
  output      logic [15:0] rom_data
);
  logic [15:0] mem [16];
  logic [3:0]  wait_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rom_ack  <= 1'b0;
      rom_data <= 16'h0000;
      wait_q   <= 4'h0;
    end else if (rom_req && !rom_ack && !mute && wait_q == dly) begin
      rom_ack  <= 1'b1;
      rom_data <= mem[rom_addr[4:1]];
      wait_q   <= 4'h0;
    end else begin
      rom_ack  <= 1'b0;
      rom_data <= ~rom_data;
      wait_q   <= (rom_req && !rom_ack && !mute) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

// ### sim/scl_loader_assertions.sv
// Port checks for the ROM loader
`timescale 1ns/10ps
module scl_loader_checker
  import scl_pkg::*;
(
  // Watched loader ports
  input wire logic                             mclk,
  input wire logic                             rst,
  input wire logic                             rom_req,
  input wire logic [7:0]                       rom_addr,
  input wire logic                             rom_ack,
  input wire logic [15:0]                      rom_data,
  input wire scl_port_cfg_type [NUM_PORTS-1:0] port_cfg,
  input wire logic                             load_busy,
  input wire logic                             load_done,
  input wire logic                             load_sig_bad
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence take_s(logic [7:0] a);
    rom_req && rom_ack && rom_addr == a;
  endsequence
  sig_check_a: assert property (take_s(8'h00) ##0 rom_data != 16'h1516
    |=> load_sig_bad && !load_busy && !rom_req) else $error("bad signature missed");
  bad_default_a: assert property (load_sig_bad |-> port_cfg == '0)
    else $error("fields loaded after bad signature");
  vc_mode_a: assert property (take_s(8'h06) |=> ##1
    port_cfg[0].ext_vc_count == $past(rom_data[0], 2) &&
    port_cfg[0].switch_mode.ct_thresh == $past(rom_data[12:11], 2)) else $error("word 06 map");
  sof_mode_a: assert property (take_s(8'h0c) |=> ##1
    port_cfg[3].tx_sof_latency_mode == $past(rom_data[11], 2) &&
    port_cfg[3].boundary_4k_check == $past(rom_data[15], 2)) else $error("word 0c map");
  margin_map_a: assert property (take_s(8'h0e) |=> ##1 {port_cfg[2].obff_enable,
    port_cfg[2].margin_drive_level_half, port_cfg[2].margin_drive_level_b,
    port_cfg[2].margin_drive_level_a} == $past(rom_data, 2)) else $error("word 0e map");
  phy_high_a: assert property (take_s(8'h18) |=> ##1
    port_cfg[4].vendor_phy_control_a[31:16] == $past(rom_data, 2)) else $error("word 18 map");
  delta_done_a: assert property (take_s(8'h1e) |=> ##1 load_done &&
    port_cfg[5].drive_level_delta_half == $past(rom_data[5:4], 2)) else $error("word 1e map");
  port_same_a: assert property (load_done |-> port_cfg[1] == port_cfg[2] &&
    port_cfg[2] == port_cfg[3] && port_cfg[3] == port_cfg[4] && port_cfg[4] == port_cfg[5] &&
    !port_cfg[0].bw_notify_cap && !port_cfg[0].int_pin_a_req) else $error("ports differ");
endmodule
bind scl_loader scl_loader_checker u_chk (.mclk, .rst, .rom_req, .rom_addr, .rom_ack,
  .rom_data, .port_cfg, .load_busy, .load_done, .load_sig_bad);

// ### sim/test_scl_loader.sv
// Self-checking bench for the ROM loader
`timescale 1ns/10ps
module test_scl_loader
  import scl_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, load_req = 1'b0, mute = 1'b0, rom_req, rom_ack;
  logic [3:0] dly = 4'h0;
  logic [7:0] rom_addr;
  logic [15:0] rom_data, cfg_vendor_id, cfg_device_id, cfg_subsys_vendor_id, cfg_subsys_id;
  scl_port_cfg_type [NUM_PORTS-1:0] port_cfg;
  logic load_busy, load_done, load_sig_bad, load_timeout;
  int err_total = 0, n_checks = 0, cyc = 0;
  scl_loader #(.ACK_TIMEOUT_CYC(64)) u_dut (.mclk, .rst, .load_req, .rom_req, .rom_addr,
    .rom_ack, .rom_data, .cfg_vendor_id, .cfg_device_id, .cfg_subsys_vendor_id,
    .cfg_subsys_id, .port_cfg, .load_busy, .load_done, .load_sig_bad, .load_timeout);
  scl_rom_model u_rom (.mclk, .rst, .dly, .mute, .rom_req, .rom_addr, .rom_ack, .rom_data);
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic restart();
    int n;
    @(posedge mclk);
    #1 load_req = 1'b1;
    @(posedge mclk);
    #1 load_req = 1'b0;
    n = 0;
    while (load_busy !== 1'b0 && n < 1000) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask
  task automatic t_pass(input logic [3:0] d);
    logic [15:0] w [16];
    scl_port_cfg_type c;
    dly = d;
    restart();
    w = u_rom.mem;
    chk({load_done, load_sig_bad, load_timeout, cfg_vendor_id}, {3'b100, w[1]});
    chk({cfg_device_id, cfg_subsys_id}, {w[2], w[5]});
    chk(cfg_subsys_vendor_id, w[4]);
    for (int p = 0; p < NUM_PORTS; p++) begin
      c = port_cfg[p];
      chk({c.ext_vc_count, c.l0s_exit_latency, c.l1_exit_latency, c.clock_pm_cap},
        {w[3][0], w[3][3:1], w[3][6:4], w[3][7]});
      chk(c.switch_mode, (p == 0) ? {w[3][15], w[3][9:8], w[3][14:10]} : 8'h00);
      chk({c.pm_cap_disable, c.compliance_parity_disable, c.msi_cap_disable, c.role_based_err,
        c.aspm_support, c.max_payload_support}, w[6][7:0]);
      chk({c.post_pass_np, c.ordering_frozen, c.pm_data_sel_writable, c.boundary_4k_check,
        c.tx_sof_latency_mode}, {w[6][8], w[6][10], w[6][13], w[6][15], w[6][11]});
      chk({c.bw_notify_cap, c.surprise_down_cap, c.ltr_enable},
        {(p != 0) && w[6][9], w[6][12], w[6][14]});
      chk({c.obff_enable, c.margin_drive_level_half, c.margin_drive_level_b,
        c.margin_drive_level_a}, w[7]);
      chk({c.gen2_mode_control, c.nominal_drive_level_half, c.nominal_drive_level_b,
        c.nominal_drive_level_a}, w[8]);
      chk({c.int_pin_a_req, c.gen2_post_emphasis_nominal_b, c.gen2_post_emphasis_nominal_a,
        c.gen1_post_emphasis_nominal}, {(p != 0) && w[9][15], w[9][14:0]});
      chk({c.arbiter_channel_flag_select, c.grant_fail_to_idle, c.request_abort_select,
        c.half_swing_emphasis_delta, c.receiver_detect_microseconds, c.transmit_phy_latency},
        w[10][14:0]);
      chk(c.vendor_phy_control_a, {w[12], w[11]});
      chk(c.vendor_phy_control_b, {w[14][7:0], w[13]});
      chk({c.refclk_buffer_control, c.drive_level_delta_half, c.drive_level_delta_b,
        c.drive_level_delta_a}, {w[14][15:8], w[15][5:0]});
    end
    $display("load pass with ack latency %0d done", d);
  endtask
  task automatic t_bad_sig();
    u_rom.mem[0] = 16'h1517;
    restart();
    chk({load_done, load_sig_bad, rom_req}, 3'b010);
    chk({port_cfg == '0, cfg_vendor_id}, {1'b1, ID_VENDOR_DEF});
    u_rom.mem[0] = 16'h1516;
    $display("bad signature test done");
  endtask
  task automatic t_timeout();
    mute = 1'b1;
    restart();
    chk({load_done, load_timeout, rom_req}, 3'b010);
    mute = 1'b0;
    $display("timeout test done");
  endtask
  task automatic t_reset();
    @(posedge mclk);
    #1 load_req = 1'b1;
    @(posedge mclk);
    #1 load_req = 1'b0;
    repeat (40) @(posedge mclk);
    #1 rst = 1'b1;
    @(posedge mclk);
    #1 chk({load_busy, load_done, rom_req, port_cfg == '0, cfg_vendor_id},
      {4'b1001, ID_VENDOR_DEF});
    rst = 1'b0;
    $display("mid-run reset test done");
  endtask
  initial begin
    for (int i = 0; i < 16; i++) begin
      u_rom.mem[i] = 16'h1516 ^ (16'h9e37 * i[15:0]);
    end
    repeat (4) @(posedge mclk);
    #1 rst = 1'b0;
    t_pass(4'h0);
    t_bad_sig();
    t_pass(4'h3);
    t_timeout();
    t_reset();
    t_pass(4'h1);
    report_and_stop();
  end
endmodule
